// ===== logic/dlr_pkg.sv
// Shared constants for the DAC update-control link: command codes,
// frame field positions, timing counts and the host register map.
// Assumes a 100 MHz pclk on both ends.
package dlr_pkg;
	// ==========================================================
	// Frame layout
	localparam int FRAME_BITS = 24;
	localparam int CMD_MSB = 23;
	localparam int CMD_LSB = 20;
	localparam int ADDR_MSB = 19;
	localparam int ADDR_LSB = 16;
	localparam int DATA_MSB = 15;
	localparam int DATA_LSB = 6;
	localparam int MASK_MSB = 3;
	localparam int REF_BIT = 0;
	localparam int NUM_CH = 4;
	localparam int CODE_W = 10;
	localparam logic [4:0] FRAME_BITS_5 = 5'h18;

	// ==========================================================
	// Command nibble codes
	localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
	localparam logic [3:0] CMD_UPDATE_DAC = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
	localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
	localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
	localparam logic [3:0] CMD_REF_SETUP = 4'h7;

	// ==========================================================
	// Reset values and clear codes
	localparam logic [9:0] CODE_ZERO = 10'h000;
	localparam logic [9:0] CODE_MID = 10'h200;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic REF_OFF_RESET = 1'b0;

	// ==========================================================
	// Timing
	localparam int CLK_NS = 10;
	localparam int POR_TIME_NS = 1000;
	localparam int POR_CYCLES = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int HW_RESET_MIN_NS = 30;
	localparam int HW_RESET_CYCLES =
		(HW_RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCLK_HALF_CYCLES = 4;

	// ==========================================================
	// Host APB register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FRAME = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam int CTRL_STROBE_BIT = 0;
	localparam int CTRL_RESET_LEVEL_SELECT_BIT = 1;
	localparam int CTRL_HWRST_BIT = 2;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_HWRST_BIT = 1;
endpackage

// ===== logic/dlr_link_if.sv
// Link between host controller and DAC control device: serial clock,
// data, frame sync, load strobe, hardware reset and reset level pin.
// The host drives every wire; the device only listens.
`timescale 1ns/100ps
interface dlr_link_if;
	logic sclk;
	logic sdin;
	logic sync_n;
	logic load_strobe_n;
	logic hw_reset_n;
	logic reset_level_select;

	modport host (
		output sclk,
		output sdin,
		output sync_n,
		output load_strobe_n,
		output hw_reset_n,
		output reset_level_select
	);
	modport device (
		input sclk,
		input sdin,
		input sync_n,
		input load_strobe_n,
		input hw_reset_n,
		input reset_level_select
	);
endinterface

// ===== logic/dlr_device.sv
// DAC update control: receives 24-bit command frames, holds input and
// DAC registers per channel, load mask, reference setup and resets.
// Assumes all link pins are asynchronous to pclk; they are synchronised.
`timescale 1ns/100ps

// Operation
// - Deferred update on later strobe falling edge
// - Command 0101 loads mask, ignores address
// - Mask bits reset to zero
// - Set mask bit hides strobe from channel
// - 0001 writes input, DAC only strobe low
// - 0010 copies input to DAC always
// - 0011 writes input and DAC always
// - Strobe falling edge updates unmasked channels
// - Strobe held low ignores mask bits
// - Hardware reset clears to selected level
// - Host holds reset low 30 ns
// - No updates during reset; hold cleared value
// - Command 0110 restores power-on state
// - Ignore strobe and reset during power-on
// - Power-up level from reset level pin
// - Command 0111 sets reference off bit
// - Command in DB23-20, address DB19-16
// - 24-bit word valid at sync rise
// - 0001 with strobe low updates both
module dlr_device
	import dlr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	dlr_link_if.device link,
	output logic [NUM_CH*CODE_W-1:0] analog_output_code,
	output logic reference_enable,
	output logic por_busy
);
	// ==========================================================
	// Pin synchronisers
	localparam int PINS = 6;
	// Idle levels of the host pins, so no false edge follows reset
	localparam logic [PINS-1:0] PIN_IDLE = 6'h2e;
	localparam int P_SCLK = 5;
	localparam int P_SDIN = 4;
	localparam int P_SYNC = 3;
	localparam int P_STRB = 2;
	localparam int P_HRST = 1;
	localparam int P_RSEL = 0;

	logic [PINS-1:0] pin_raw;
	logic [PINS-1:0] meta_reg;
	logic [PINS-1:0] sync_reg;
	logic [PINS-1:0] prev_reg;

	assign pin_raw = {link.sclk, link.sdin, link.sync_n,
		link.load_strobe_n, link.hw_reset_n, link.reset_level_select};

	// Two flops per pin, then a third copy for edge detection only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= PIN_IDLE;
			sync_reg <= PIN_IDLE;
			prev_reg <= PIN_IDLE;
		end
		else
		begin
			meta_reg <= pin_raw;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	wire sclk_fall = prev_reg[P_SCLK] & ~sync_reg[P_SCLK];
	wire sync_fall = prev_reg[P_SYNC] & ~sync_reg[P_SYNC];
	wire sync_rise = ~prev_reg[P_SYNC] & sync_reg[P_SYNC];
	wire strobe_fall = prev_reg[P_STRB] & ~sync_reg[P_STRB];
	wire strobe_low = ~sync_reg[P_STRB];

	// ==========================================================
	// Power-on interval
	logic [7:0] por_cnt_reg;
	wire por_active = (por_cnt_reg != 8'(POR_CYCLES));

	// ==========================================================
	// Frame receiver
	logic [FRAME_BITS-1:0] shift_reg;
	logic [4:0] bit_cnt_reg;

	// Bits enter at the LSB so the first bit ends up as DB23
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shift_reg <= '0;
			bit_cnt_reg <= 5'h00;
		end
		else if (sync_fall)
			bit_cnt_reg <= 5'h00;
		else if (sclk_fall && !sync_reg[P_SYNC])
		begin
			shift_reg <= {shift_reg[FRAME_BITS-2:0],
				sync_reg[P_SDIN]};
			if (bit_cnt_reg != 5'h1f)
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// Only an exact 24-bit frame executes; short or long ones drop
	wire frame_done = sync_rise &&
		(bit_cnt_reg == FRAME_BITS_5);
	wire [3:0] command_nibble = shift_reg[CMD_MSB:CMD_LSB];
	wire [NUM_CH-1:0] addr_sel = shift_reg[ADDR_MSB:ADDR_LSB];
	wire [CODE_W-1:0] data_code = shift_reg[DATA_MSB:DATA_LSB];

	wire do_write_in = frame_done && command_nibble == CMD_WRITE_INPUT;
	wire do_update = frame_done && command_nibble == CMD_UPDATE_DAC;
	wire do_wr_upd = frame_done && command_nibble == CMD_WRITE_UPDATE;
	wire do_mask = frame_done && command_nibble == CMD_LOAD_MASK;
	wire do_soft_rst = frame_done && command_nibble == CMD_SOFT_RESET;
	wire do_ref = frame_done && command_nibble == CMD_REF_SETUP;

	// ==========================================================
	// Reset control
	// Counts up after reset release; a soft reset re-runs the whole
	// interval so the strap is sampled again
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			por_cnt_reg <= 8'h00;
		else if (do_soft_rst)
			por_cnt_reg <= 8'h00;
		else if (por_active)
			por_cnt_reg <= por_cnt_reg + 8'h01;
	end

	// Hardware reset is ignored while power-on runs, which clears anyway
	wire hw_reset_act = ~sync_reg[P_HRST] & ~por_active;
	wire full_reset = por_active | do_soft_rst;
	wire clear_all = full_reset | hw_reset_act;
	wire [CODE_W-1:0] clear_code = sync_reg[P_RSEL] ?
		CODE_MID : CODE_ZERO;

	// ==========================================================
	// Load mask and reference setup
	logic [NUM_CH-1:0] load_mask_reg;
	logic ref_off_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			load_mask_reg <= MASK_RESET;
			ref_off_reg <= REF_OFF_RESET;
		end
		else if (full_reset)
		begin
			load_mask_reg <= MASK_RESET;
			ref_off_reg <= REF_OFF_RESET;
		end
		else
		begin
			if (do_mask)
				load_mask_reg <= shift_reg[MASK_MSB:0];
			if (do_ref)
				ref_off_reg <= shift_reg[REF_BIT];
		end
	end

	assign reference_enable = ~ref_off_reg;
	assign por_busy = por_active;

	// ==========================================================
	// Per-channel input and DAC registers
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch = ch + 1)
		begin : g_ch
			logic [CODE_W-1:0] input_reg;
			logic [CODE_W-1:0] dac_reg;
			logic [CODE_W-1:0] input_next;
			logic [CODE_W-1:0] dac_next;
			wire hit = addr_sel[ch];
			// Strobe edge counts only for unmasked channels
			wire edge_load = strobe_fall &
				~load_mask_reg[ch];

			// Write-type commands take the new code into input
			assign input_next = clear_all ? clear_code :
				(hit && (do_write_in || do_wr_upd)) ? data_code :
				input_reg;

			// Command writes win over a coincident strobe edge;
			// a low strobe passes 0001 data regardless of mask
			assign dac_next = clear_all ? clear_code :
				(hit && do_write_in && strobe_low) ?
				data_code :
				(hit && do_update) ? input_reg :
				(hit && do_wr_upd) ? data_code :
				edge_load ? input_reg :
				dac_reg;

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					input_reg <= CODE_ZERO;
					dac_reg <= CODE_ZERO;
				end
				else
				begin
					input_reg <= input_next;
					dac_reg <= dac_next;
				end
			end

			assign analog_output_code[ch*CODE_W +: CODE_W] = dac_reg;
		end
	endgenerate
endmodule // dlr_device

// ===== logic/dlr_host.sv
// Host controller: APB slave registers take frames and pin levels from
// software and drive the serial link, strobe and hardware reset pins.
// Assumes a single pclk domain; the link clock is divided from it.
`timescale 1ns/100ps
module dlr_host
	import dlr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	dlr_link_if.host link
);
	typedef enum {ST_IDLE, ST_SHIFT, ST_END, ST_GAP} dlr_state_type;

	// ==========================================================
	// APB decode
	logic [1:0] ctrl_reg;
	logic [31:0] prdata_reg;
	logic [3:0] hrst_cnt_reg;
	dlr_state_type state_reg;

	wire busy = (state_reg != ST_IDLE);
	wire hrst_busy = (hrst_cnt_reg != 4'h0);
	wire sel_ctrl = (paddr == OFS_CTRL);
	wire sel_frame = (paddr == OFS_FRAME);
	wire sel_stat = (paddr == OFS_STATUS);
	wire mapped = sel_ctrl | sel_frame | sel_stat;
	wire access = psel & penable;
	// A new frame waits until the previous one has left the link
	wire frame_stall = sel_frame & pwrite & busy;
	wire wr_done = access & pready & pwrite & mapped;
	wire start = wr_done & sel_frame;

	assign pready = ~frame_stall;
	assign pslverr = access & ~mapped;
	assign prdata = prdata_reg;

	// Read data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_reg <= sel_ctrl ? {30'h0, ctrl_reg} :
				sel_stat ? {30'h0, hrst_busy, busy} : 32'h0000_0000;
	end

	// Control levels and reset pulse length
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= CTRL_RESET;
			hrst_cnt_reg <= 4'h0;
		end
		else
		begin
			if (wr_done && sel_ctrl)
				ctrl_reg <= pwdata[1:0];
			if (wr_done && sel_ctrl && pwdata[CTRL_HWRST_BIT])
				hrst_cnt_reg <= 4'(HW_RESET_CYCLES);
			else if (hrst_busy)
				hrst_cnt_reg <= hrst_cnt_reg - 4'h1;
		end
	end

	assign link.load_strobe_n = ctrl_reg[CTRL_STROBE_BIT];
	assign link.reset_level_select = ctrl_reg[CTRL_RESET_LEVEL_SELECT_BIT];
	assign link.hw_reset_n = ~hrst_busy;

	// ==========================================================
	// Link clock divider and shifter
	logic [2:0] div_reg;
	logic [FRAME_BITS-1:0] out_reg;
	logic [4:0] bits_reg;
	logic sclk_reg;
	logic sdin_reg;
	logic sync_n_reg;
	wire tick = (div_reg == 3'(SCLK_HALF_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_reg <= 3'h0;
		else if (start || tick)
			div_reg <= 3'h0;
		else
			div_reg <= div_reg + 3'h1;
	end

	// Data changes while sclk is high; the device samples on the fall
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ST_IDLE;
			out_reg <= '0;
			bits_reg <= 5'h00;
			sclk_reg <= 1'b1;
			sdin_reg <= 1'b0;
			sync_n_reg <= 1'b1;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
					if (start)
					begin
						out_reg <= pwdata[FRAME_BITS-1:0];
						sdin_reg <= pwdata[CMD_MSB];
						sync_n_reg <= 1'b0;
						bits_reg <= 5'h00;
						state_reg <= ST_SHIFT;
					end
				ST_SHIFT:
					if (tick && sclk_reg)
					begin
						sclk_reg <= 1'b0;
						bits_reg <= bits_reg + 5'h01;
					end
					else if (tick)
					begin
						sclk_reg <= 1'b1;
						if (bits_reg == FRAME_BITS_5)
							state_reg <= ST_END;
						else
						begin
							out_reg <= {out_reg[FRAME_BITS-2:0], 1'b0};
							sdin_reg <= out_reg[CMD_MSB-1];
						end
					end
				ST_END:
					if (tick)
					begin
						sync_n_reg <= 1'b1;
						state_reg <= ST_GAP;
					end
				ST_GAP:
					if (tick)
						state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	assign link.sclk = sclk_reg;
	assign link.sdin = sdin_reg;
	assign link.sync_n = sync_n_reg;
endmodule // dlr_host

// ===== verification/dlr_chk.sv
// Checker for the link wires between the host and the DAC control end.
// Assumes the host changes every link pin only on rising pclk edges.
`timescale 1ns/100ps
module dlr_chk
	import dlr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sclk,
	input wire logic sdin,
	input wire logic sync_n,
	input wire logic load_strobe_n,
	input wire logic hw_reset_n,
	input wire logic reset_level_select
);
	// ==========================================================
	// Helper: count sclk falls inside a frame, cleared between frames
	logic sclk_reg;
	logic [4:0] falls_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_reg <= 1'b1;
			falls_reg <= 5'h00;
		end
		else
		begin
			sclk_reg <= sclk;
			if (sync_n)
				falls_reg <= 5'h00;
			else if (sclk_reg && !sclk)
				falls_reg <= falls_reg + 5'h01;
		end
	end

	// ==========================================================
	// Link timing
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Each sclk half period is four pclk cycles
	sequence s_high_half;
		sclk [*4];
	endsequence
	sequence s_low_half;
		!sclk [*4] ##1 sclk;
	endsequence

	AST_IDLE_HIGH: assert property (sync_n |-> sclk)
		else $error("sclk low outside a frame");
	AST_FIRST_FALL: assert property ($fell(sync_n) |->
		s_high_half ##1 !sclk)
		else $error("first sclk fall misplaced");
	AST_LOW_HALF: assert property ($fell(sclk) |-> s_low_half)
		else $error("sclk low half wrong");
	AST_HIGH_HALF: assert property ($rose(sclk) |-> s_high_half)
		else $error("sclk high half wrong");
	AST_FRAME_LEN: assert property ($rose(sync_n) |->
		falls_reg == FRAME_BITS_5)
		else $error("frame not 24 bits");
	AST_SYNC_END: assert property ($rose(sync_n) |->
		$past(sclk, 4) && $past(sclk))
		else $error("sync rose too soon after sclk");
	AST_SYNC_GAP: assert property ($rose(sync_n) |-> sync_n [*4])
		else $error("gap after frame too short");
	AST_DATA_HOLD: assert property (!sync_n && !$fell(sync_n) &&
		!$rose(sclk) |-> $stable(sdin))
		else $error("sdin moved away from sclk rise");
	AST_RST_PULSE: assert property ($fell(hw_reset_n) |->
		!hw_reset_n [*3] ##1 hw_reset_n)
		else $error("reset pulse not three cycles");
endmodule // dlr_chk

// ===== verification/tb_top.sv
// Bench for the DAC control pair: APB drives the host, device codes
// are compared. Assumes one pclk for both ends; dlr_chk watches wires.
`timescale 1ns/100ps
module tb_top;
	import dlr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, slv;
	logic [7:0] paddr;
	logic [31:0] pwdata, q, prdata;
	logic pready, pslverr, ref_en, por_busy;
	logic [NUM_CH*CODE_W-1:0] aout;
	int n_fail, samples_checked;

	dlr_link_if link();
	dlr_host dlr_host_i(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	dlr_device dlr_device_i(.pclk(pclk), .presetn(presetn),
		.link(link), .analog_output_code(aout),
		.reference_enable(ref_en), .por_busy(por_busy));
	dlr_chk dlr_chk_i(.pclk(pclk), .presetn(presetn),
		.sclk(link.sclk), .sdin(link.sdin), .sync_n(link.sync_n),
		.load_strobe_n(link.load_strobe_n),
		.hw_reset_n(link.hw_reset_n),
		.reset_level_select(link.reset_level_select));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ==========================================================
	// Tasks
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s exp %0h got %0h", n, e, g);
		end
	endtask
	task tmo(input logic bad);
		if (bad)
		begin
			n_fail++;
			conclude;
		end
	endtask
	// One APB transfer; request held until pready is seen at a rising
	// edge, and the answer is taken at that same edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 400; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
			begin
				q = prdata;
				slv = pslverr;
				break;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		tmo(i == 400);
	endtask
	// Send a frame and wait until the link is idle again
	task frame(input logic [23:0] f);
		int i;
		apb(1'b1, OFS_FRAME, {8'h00, f});
		for (i = 0; i < 100; i++)
		begin
			apb(1'b0, OFS_STATUS, 32'h0);
			if (q[STAT_BUSY_BIT] === 1'b0)
				break;
		end
		tmo(i == 100);
		repeat (4) @(posedge pclk);
	endtask
	task ctrl(input logic [31:0] v);
		apb(1'b1, OFS_CTRL, v);
		repeat (8) @(posedge pclk);
	endtask
	task wait_por;
		int i;
		for (i = 0; i < 300; i++)
		begin
			@(negedge pclk);
			if (por_busy === 1'b0)
				break;
		end
		@(posedge pclk);
		tmo(i == 300);
	endtask
	function automatic logic [23:0] fw(input logic [3:0] c,
		input logic [3:0] a, input logic [9:0] v);
		return {c, a, v, 6'h00};
	endfunction
	function automatic logic [31:0] ch(input int n);
		return {22'h0, aout[n*CODE_W +: CODE_W]};
	endfunction

	// ==========================================================
	// Main sequence
	initial
	begin
		n_fail = 0;
		samples_checked = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("por_busy", 32'h1, {31'h0, por_busy});
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", 32'h1, q);
		apb(1'b0, 8'h0c, 32'h0);
		chk("slverr", 32'h1, {31'h0, slv});
		chk("unmapped", 32'h0, q);
		wait_por;
		chk("ref", 32'h1, {31'h0, ref_en});
		for (int n = 0; n < NUM_CH; n++)
			chk("code", 32'h0, ch(n));
		// Reference off and on, address ignored
		frame({CMD_REF_SETUP, 4'ha, 16'h0001});
		chk("ref", 32'h0, {31'h0, ref_en});
		frame({CMD_REF_SETUP, 4'h5, 16'h0000});
		chk("ref", 32'h1, {31'h0, ref_en});
		// Deferred update by a later strobe fall
		frame(fw(CMD_WRITE_INPUT, 4'h1, 10'h155));
		chk("code0", 32'h0, ch(0));
		ctrl(32'h0);
		chk("strobe pin", 32'h0, {31'h0, link.load_strobe_n});
		chk("code0", 32'h155, ch(0));
		ctrl(32'h1);
		// Mask channel 1, then pulse the strobe
		frame({CMD_LOAD_MASK, 4'hf, 16'h0002});
		frame(fw(CMD_WRITE_INPUT, 4'h3, 10'h0aa));
		ctrl(32'h0);
		ctrl(32'h1);
		chk("code0", 32'h0aa, ch(0));
		chk("code1", 32'h0, ch(1));
		frame(fw(CMD_UPDATE_DAC, 4'h2, 10'h3c3));
		chk("code1", 32'h0aa, ch(1));
		frame(fw(CMD_WRITE_UPDATE, 4'h4, 10'h3ff));
		chk("code2", 32'h3ff, ch(2));
		// Strobe held low: write goes through despite the mask
		ctrl(32'h0);
		frame(fw(CMD_WRITE_INPUT, 4'h2, 10'h123));
		chk("code1", 32'h123, ch(1));
		// Hardware reset to midscale
		ctrl(32'h3);
		apb(1'b1, OFS_CTRL, 32'h7);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", 32'h2, q);
		repeat (8) @(posedge pclk);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", 32'h3, q);
		for (int n = 0; n < NUM_CH; n++)
			chk("code", 32'h200, ch(n));
		// Software reset restores power-on state, mask included
		ctrl(32'h1);
		frame({CMD_REF_SETUP, 4'h0, 16'h0001});
		frame({CMD_SOFT_RESET, 20'h00000});
		chk("por_busy", 32'h1, {31'h0, por_busy});
		wait_por;
		chk("ref", 32'h1, {31'h0, ref_en});
		chk("code3", 32'h0, ch(3));
		frame(fw(CMD_WRITE_INPUT, 4'h2, 10'h2a5));
		ctrl(32'h0);
		ctrl(32'h1);
		chk("code1", 32'h2a5, ch(1));
		conclude;
	end
endmodule // tb_top
